// ### rtl/pin_level_register_pkg.sv
// Constants for the eight-pin shared port: register map, reset values and
// the pin positions of the peripheral functions.
// Assumes an APB bus with 32-bit data and one word per register.
package pin_mux_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [11:0] PIN_LEVEL_OFF    = 12'h000;
  localparam logic [11:0] OUT_LATCH_OFF    = 12'h004;
  localparam logic [11:0] DIRECTION_OFF    = 12'h008;
  localparam logic [11:0] PERIPH_CTRL_OFF  = 12'h00c;
  localparam logic [11:0] PERIPH_STAT_OFF  = 12'h010;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] DIRECTION_RST   = 8'hff;
  localparam logic [7:0] OUT_LATCH_RST   = 8'h00;
  localparam logic [7:0] PERIPH_CTRL_RST = 8'h00;

  // ----------------------------------------------------------------------
  // Peripheral control register fields
  // ----------------------------------------------------------------------
  localparam int LF_OSC_EN_BIT     = 0;
  localparam int CCP2_PIN_SEL_BIT  = 1;
  localparam int CCP1_EN_BIT       = 2;
  localparam int CCP2_EN_BIT       = 3;
  localparam int SPI_EN_BIT        = 4;
  localparam int I2C_EN_BIT        = 5;
  localparam int USART_EN_BIT      = 6;
  localparam int USART_SYNC_BIT    = 7;

  // ----------------------------------------------------------------------
  // Pin positions
  // ----------------------------------------------------------------------
  localparam int PIN_OSC_OUT   = 0;
  localparam int PIN_OSC_IN    = 1;
  localparam int PIN_CCP1      = 2;
  localparam int PIN_SCK       = 3;
  localparam int PIN_SDI       = 4;
  localparam int PIN_SDO       = 5;
  localparam int PIN_USART_CK  = 6;
  localparam int PIN_USART_DT  = 7;

  localparam int PIN_SYNC_STAGES = 3;

endpackage

// ### rtl/pin_sync_if.sv
// Carries raw pin levels into the synchroniser and filtered levels back.
// Assumes both ends share clk_i.
`timescale 1ns/1ps
interface pin_sync_if;
  logic [7:0] raw;
  logic [7:0] level;
  modport owner (output raw, input level);
  modport sync  (input raw, output level);
endinterface

// ### rtl/pin_sync.sv
// Three-stage synchroniser for the eight pin inputs.
// Assumes pins are asynchronous to clk_i; a change is accepted once the
// second and third stages agree.
`timescale 1ns/1ps
module pin_sync
  import pin_mux_pkg::*;
(
  input  wire logic   clk_i,
  input  wire logic   rst_n_i,
  pin_sync_if.sync    sif
);

  typedef struct packed {
    logic [7:0] s1;
    logic [7:0] s2;
    logic [7:0] s3;
    logic [7:0] level;
  } sync_state_t;

  sync_state_t st_r;
  sync_state_t st_nxt;

  // Shift the stages; the first stage feeds only the second.
  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = sif.raw;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    for (int i = 0; i < 8; i++) begin
      if (st_r.s2[i] == st_r.s3[i]) begin
        st_nxt.level[i] = st_r.s3[i];
      end
    end
  end

  // Inputs read as zero until the pins have settled.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign sif.level = st_r.level;

endmodule

// ### rtl/port_c_pin_mux.sv
// Eight-pin general purpose port shared with on-chip peripherals, with
// an APB register slave.
// Assumes peripherals present per-pin drive and enable signals on clk_i
// and that the pad ring resolves the level from pin_oe_o.
`timescale 1ns/1ps

// Operation
// - Direction one is input, zero output.
// - Writing pin or latch register updates latches.
// - Oscillator enable disables pin 0 digital I/O.
// - Oscillator enable disables pin 1 digital I/O.
// - Pin select routes second compare unit to pin 1.
// - Pin 2 carries first compare unit.
// - PWM channel A may tri-state on shutdown.
// - Pin 3 carries SPI clock both ways.
// - I2C uses pins 3, 4; module picks threshold.
// - Pin 4 SPI input, pin 5 SPI output.
// - USART receive taken from pin 7.
// - Synchronous USART clock pin 6, data pin 7.
// - Comparator output sets its own direction.
// - All pins inputs after reset.
// - Direction reads return stored contents.
module port_c_pin_mux
  import pin_mux_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // APB slave.
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  input  wire logic [3:0]  pstrb_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // Pads.
  input  wire logic [7:0]  pin_i,
  output logic [7:0]       pin_o,
  output logic [7:0]       pin_oe_o,
  output logic [1:0]       osc_analog_en_o,
  output logic [1:0]       i2c_schmitt_sel_o,
  // Fixed pin-select configuration bit.
  input  wire logic        second_ccp_pin_select_cfg_i,
  // Capture/compare units.
  input  wire logic        ccp1_out_i,
  input  wire logic        ccp1_out_en_i,
  input  wire logic        ccp1_shutdown_tri_i,
  input  wire logic        ccp2_out_i,
  input  wire logic        ccp2_out_en_i,
  input  wire logic        ccp2_shutdown_tri_i,
  output logic             ccp1_capture_o,
  output logic             ccp2_capture_o,
  output logic             timer_counter_clock_in_o,
  // Serial module.
  input  wire logic        spi_clock_pin_i,
  input  wire logic        spi_data_out_pin_i,
  input  wire logic        i2c_clock_pin_oe_i,
  input  wire logic        i2c_data_pin_oe_i,
  input  wire logic        i2c_schmitt_i,
  output logic             spi_clock_pin_o,
  output logic             spi_data_in_pin_o,
  output logic             i2c_clock_pin_o,
  output logic             i2c_data_pin_o,
  // Comparator.
  input  wire logic        comparator_two_output_i,
  input  wire logic        comparator_two_output_en_i,
  // USART.
  input  wire logic        usart_transmit_pin_i,
  input  wire logic        usart_sync_clock_pin_i,
  input  wire logic        usart_sync_data_pin_i,
  input  wire logic        usart_sync_tx_i,
  output logic             usart_receive_pin_o,
  output logic             usart_sync_clock_pin_o,
  output logic             usart_sync_data_pin_o
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  latch;
    logic [7:0]  dir;
    logic [7:0]  ctrl;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [7:0]  pin_out;
    logic [7:0]  pin_oe;
    logic [1:0]  osc_en;
    logic [1:0]  i2c_sel;
    logic        ccp1_cap;
    logic        ccp2_cap;
    logic        tmr_ck;
    logic        spi_ck;
    logic        spi_di;
    logic        i2c_ck;
    logic        i2c_dt;
    logic        rx;
    logic        sck_in;
    logic        sdt_in;
  } port_state_t;

  port_state_t st_r;
  port_state_t st_nxt;

  pin_sync_if sif ();

  assign sif.raw = pin_i;

  pin_sync u_sync (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .sif     (sif)
  );

  logic [7:0] lvl;
  assign lvl = sif.level;

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    logic       lf_en;
    logic       spi_en;
    logic       i2c_en;
    logic       us_en;
    logic       us_sync;
    logic       ccp2_here;
    logic [7:0] drv;
    logic [7:0] oe;
    logic [7:0] wdat;
    logic       access;
    logic       mapped;
    lf_en     = st_r.ctrl[LF_OSC_EN_BIT];
    spi_en    = st_r.ctrl[SPI_EN_BIT];
    i2c_en    = st_r.ctrl[I2C_EN_BIT];
    us_en     = st_r.ctrl[USART_EN_BIT];
    us_sync   = st_r.ctrl[USART_SYNC_BIT];
    ccp2_here = second_ccp_pin_select_cfg_i & st_r.ctrl[CCP2_EN_BIT];
    st_nxt    = st_r;

    drv = st_r.latch;
    oe  = ~st_r.dir;

    if (ccp2_here && !st_r.dir[PIN_OSC_IN]) begin
      drv[PIN_OSC_IN] = ccp2_out_i;
      oe[PIN_OSC_IN]  = ccp2_out_en_i & ~ccp2_shutdown_tri_i;
    end
    if (st_r.ctrl[CCP1_EN_BIT] && !st_r.dir[PIN_CCP1]) begin
      drv[PIN_CCP1] = ccp1_out_i;
      oe[PIN_CCP1]  = ccp1_out_en_i & ~ccp1_shutdown_tri_i;
    end
    if (spi_en && !st_r.dir[PIN_SCK]) begin
      drv[PIN_SCK] = spi_clock_pin_i;
    end
    if (spi_en && !st_r.dir[PIN_SDO]) begin
      drv[PIN_SDO] = spi_data_out_pin_i;
    end
    if (comparator_two_output_en_i) begin
      drv[PIN_SDO] = comparator_two_output_i;
      oe[PIN_SDO]  = 1'b1;
    end
    if (i2c_en) begin
      drv[PIN_SCK] = 1'b0;
      oe[PIN_SCK]  = i2c_clock_pin_oe_i;
      drv[PIN_SDI] = 1'b0;
      oe[PIN_SDI]  = i2c_data_pin_oe_i;
    end
    if (us_en && us_sync) begin
      drv[PIN_USART_CK] = usart_sync_clock_pin_i;
      oe[PIN_USART_CK]  = usart_sync_tx_i;
      drv[PIN_USART_DT] = usart_sync_data_pin_i;
      oe[PIN_USART_DT]  = usart_sync_tx_i;
    end else if (us_en) begin
      drv[PIN_USART_CK] = usart_transmit_pin_i;
      oe[PIN_USART_CK]  = 1'b1;
    end
    if (lf_en) begin
      drv[PIN_OSC_OUT] = 1'b0;
      oe[PIN_OSC_OUT]  = 1'b0;
      drv[PIN_OSC_IN]  = 1'b0;
      oe[PIN_OSC_IN]   = 1'b0;
    end
    st_nxt.pin_out = drv;
    st_nxt.pin_oe  = oe;
    st_nxt.osc_en  = {lf_en, lf_en};
    st_nxt.i2c_sel = {2{i2c_en & i2c_schmitt_i}};

    // Peripheral inputs, masked when the pin is analog.
    st_nxt.tmr_ck   = ~lf_en & lvl[PIN_OSC_OUT];
    st_nxt.ccp2_cap = ccp2_here & ~lf_en & st_r.dir[PIN_OSC_IN]
                      & lvl[PIN_OSC_IN];
    st_nxt.ccp1_cap = st_r.dir[PIN_CCP1] & lvl[PIN_CCP1];
    st_nxt.spi_ck   = st_r.dir[PIN_SCK] & lvl[PIN_SCK];
    st_nxt.spi_di   = st_r.dir[PIN_SDI] & lvl[PIN_SDI];
    st_nxt.i2c_ck   = lvl[PIN_SCK];
    st_nxt.i2c_dt   = lvl[PIN_SDI];
    st_nxt.rx       = us_en & ~us_sync & st_r.dir[PIN_USART_DT]
                      & lvl[PIN_USART_DT];
    st_nxt.sck_in   = us_sync & ~usart_sync_tx_i & lvl[PIN_USART_CK];
    st_nxt.sdt_in   = us_sync & ~usart_sync_tx_i & st_r.dir[PIN_USART_DT]
                      & lvl[PIN_USART_DT];

    // APB: one wait state, answer in the cycle after the first access cycle.
    access = psel_i & penable_i & ~st_r.pready;
    mapped = (paddr_i == PIN_LEVEL_OFF) || (paddr_i == OUT_LATCH_OFF) ||
             (paddr_i == DIRECTION_OFF) || (paddr_i == PERIPH_CTRL_OFF) ||
             (paddr_i == PERIPH_STAT_OFF);
    wdat   = pwdata_i[7:0];
    st_nxt.pready  = access;
    st_nxt.pslverr = access & ~mapped;
    st_nxt.prdata  = '0;
    if (access && !pwrite_i) begin
      unique case (paddr_i)
        PIN_LEVEL_OFF:   st_nxt.prdata = {24'h000000, lvl};
        OUT_LATCH_OFF:   st_nxt.prdata = {24'h000000, st_r.latch};
        DIRECTION_OFF:   st_nxt.prdata = {24'h000000, st_r.dir};
        PERIPH_CTRL_OFF: st_nxt.prdata = {24'h000000, st_r.ctrl};
        PERIPH_STAT_OFF: st_nxt.prdata = {24'h000000, st_r.pin_oe};
        default:         st_nxt.prdata = '0;
      endcase
    end
    if (access && pwrite_i && pstrb_i[0]) begin
      unique case (paddr_i)
        PIN_LEVEL_OFF,
        OUT_LATCH_OFF:   st_nxt.latch = wdat;
        DIRECTION_OFF:   st_nxt.dir   = wdat;
        PERIPH_CTRL_OFF: st_nxt.ctrl  = wdat;
        default:         st_nxt.latch = st_r.latch;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  // pins come up as inputs
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r       <= '0;
      st_r.dir   <= DIRECTION_RST;
      st_r.latch <= OUT_LATCH_RST;
      st_r.ctrl  <= PERIPH_CTRL_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from the state flip-flops.
  assign prdata_o                 = st_r.prdata;
  assign pready_o                 = st_r.pready;
  assign pslverr_o                = st_r.pslverr;
  assign pin_o                    = st_r.pin_out;
  assign pin_oe_o                 = st_r.pin_oe;
  assign osc_analog_en_o          = st_r.osc_en;
  assign i2c_schmitt_sel_o        = st_r.i2c_sel;
  assign ccp1_capture_o           = st_r.ccp1_cap;
  assign ccp2_capture_o           = st_r.ccp2_cap;
  assign timer_counter_clock_in_o = st_r.tmr_ck;
  assign spi_clock_pin_o          = st_r.spi_ck;
  assign spi_data_in_pin_o        = st_r.spi_di;
  assign i2c_clock_pin_o          = st_r.i2c_ck;
  assign i2c_data_pin_o           = st_r.i2c_dt;
  assign usart_receive_pin_o      = st_r.rx;
  assign usart_sync_clock_pin_o   = st_r.sck_in;
  assign usart_sync_data_pin_o    = st_r.sdt_in;

endmodule

// ### tb/port_c_checker.sv
// Assertions bound onto the shared port block.
// Assumes only the block's own ports are visible.
`timescale 1ns/1ps
module port_c_checker (
  input wire logic        clk_i,
  input wire logic        rst_n_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pready_o,
  input wire logic [31:0] prdata_o,
  input wire logic        pslverr_o,
  input wire logic [7:0]  pin_o,
  input wire logic [7:0]  pin_oe_o,
  input wire logic [1:0]  osc_analog_en_o,
  input wire logic [1:0]  i2c_schmitt_sel_o,
  input wire logic        i2c_schmitt_i,
  input wire logic        comparator_two_output_i,
  input wire logic        comparator_two_output_en_i
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);
  // An access phase still waiting for its answer.
  sequence s_wait;
    psel_i && penable_i && !pready_o;
  endsequence
  // The comparator has asked for pin 5 for two cycles.
  sequence s_cmp;
    comparator_two_output_en_i [*2];
  endsequence
  AST_READY_NEXT: assert property (s_wait |=> pready_o)
    else $error("no answer after access");
  AST_READY_ONE: assert property (pready_o |=> !pready_o)
    else $error("ready held too long");
  AST_ERR_ZERO: assert property (pslverr_o |-> prdata_o == '0)
    else $error("error answer carries data");
  AST_RST_IN: assert property ($rose(rst_n_i) |-> !pin_oe_o)
    else $error("pin driven after reset");
  AST_OSC0: assert property (osc_analog_en_o[0] [*2] |-> !pin_oe_o[0])
    else $error("pin 0 driven with oscillator on");
  AST_OSC1: assert property (osc_analog_en_o[1] [*2] |-> !pin_oe_o[1])
    else $error("pin 1 driven with oscillator on");
  AST_CMP: assert property (s_cmp |-> pin_oe_o[5] &&
    pin_o[5] == $past(comparator_two_output_i))
    else $error("comparator not on pin 5");
  AST_SCHMITT: assert property (i2c_schmitt_sel_o[0] |->
    $past(i2c_schmitt_i))
    else $error("threshold not from serial module");
endmodule

bind port_c_pin_mux port_c_checker chk_u (.*);

// ### tb/pad_model.sv
// Board pads: the block's drive wins, else an outside driver.
// A floating pin toggles so a stale level is never read as real.
`timescale 1ns/1ps
module pad_model (
  input  wire logic       clk_i,
  input  wire logic [7:0] drv_i,
  input  wire logic [7:0] oe_i,
  input  wire logic [7:0] ext_i,
  input  wire logic [7:0] ext_en_i,
  output logic [7:0]      pad_o
);
  logic [7:0] float_r = 8'h55;
  // Floating pattern flips every cycle.
  always_ff @(posedge clk_i) begin
    float_r <= ~float_r;
  end
  // Wire level seen by the block's inputs.
  assign pad_o = (oe_i & drv_i) | (~oe_i & ext_en_i & ext_i)
               | (~oe_i & ~ext_en_i & float_r);
endmodule

// ### tb/tb_port_c_pin_mux.sv
// Self-checking bench for the shared eight-pin port.
// Assumes the checker is bound in and pad_model resolves the pins.
`timescale 1ns/1ps
module tb_port_c_pin_mux;
  import pin_mux_pkg::*;
  logic clk_i = 1'b0, rst_n_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0;
  logic pwrite_i = 1'b0, pready_o, pslverr_o, er;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
  logic [3:0] pstrb_i = 4'hf;
  logic [7:0] pin_i, pin_o, pin_oe_o, ext = 8'h00, ext_en = 8'h00;
  logic [1:0] osc_analog_en_o, i2c_schmitt_sel_o;
  logic second_ccp_pin_select_cfg_i = 1'b1, ccp1_out_i = 1'b0;
  logic ccp1_out_en_i = 1'b0, ccp1_shutdown_tri_i = 1'b0;
  logic ccp2_out_i = 1'b0, ccp2_out_en_i = 1'b0, ccp2_shutdown_tri_i = 1'b0;
  logic ccp1_capture_o, ccp2_capture_o, timer_counter_clock_in_o;
  logic spi_clock_pin_i = 1'b0, spi_data_out_pin_i = 1'b0;
  logic i2c_clock_pin_oe_i = 1'b0, i2c_data_pin_oe_i = 1'b0;
  logic i2c_schmitt_i = 1'b0, comparator_two_output_i = 1'b0;
  logic comparator_two_output_en_i = 1'b0, usart_sync_tx_i = 1'b0;
  logic usart_transmit_pin_i = 1'b0, usart_sync_clock_pin_i = 1'b0;
  logic usart_sync_data_pin_i = 1'b0, spi_clock_pin_o, spi_data_in_pin_o;
  logic i2c_clock_pin_o, i2c_data_pin_o, usart_receive_pin_o;
  logic usart_sync_clock_pin_o, usart_sync_data_pin_o;
  int fail_count = 0;
  int samples_checked = 0;

  port_c_pin_mux dut_u (.*);
  pad_model pad_u (.clk_i(clk_i), .drv_i(pin_o), .oe_i(pin_oe_o),
                   .ext_i(ext), .ext_en_i(ext_en), .pad_o(pin_i));

  // Free-running 100 MHz clock.
  initial begin
    forever #5 clk_i = ~clk_i;
  end

  // --------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------
  // Prints the counts and the verdict, then ends the run.
  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Compares one byte and reports a mismatch at once.
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer; the wait for pready is bounded.
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    bit ok = 1'b0;
    @(posedge clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    for (int i = 0; i < 9 && !ok; i++) begin
      @(posedge clk_i);
      ok = (pready_o === 1'b1);
      rd = prdata_o;
      er = pslverr_o;
    end
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    if (!ok) begin
      chk(8'h00, 8'h01);
      print_verdict();
    end
  endtask
  // Reads a register and checks its byte lane.
  task automatic rdc(input logic [11:0] a, input logic [7:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd[7:0], exp);
  endtask
  // Loads control, direction and latch, then lets the pins settle.
  task automatic cfg(input logic [7:0] c, input logic [7:0] d,
                     input logic [7:0] l);
    apb(1'b1, PERIPH_CTRL_OFF, {24'h0, c});
    apb(1'b1, DIRECTION_OFF, {24'h0, d});
    apb(1'b1, OUT_LATCH_OFF, {24'h0, l});
    repeat (3) @(posedge clk_i);
  endtask

  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  // Reset state of direction and drive.
  task automatic t_reset();
    rdc(DIRECTION_OFF, 8'hff);
    chk(pin_oe_o, 8'h00);
    $display("t_reset done");
  endtask
  // Latch writes, direction pattern and pin read-back.
  task automatic t_regs();
    apb(1'b1, PIN_LEVEL_OFF, 32'ha5);
    rdc(OUT_LATCH_OFF, 8'ha5);
    cfg(8'h00, 8'hcf, 8'h30);
    rdc(DIRECTION_OFF, 8'hcf);
    chk(pin_oe_o, 8'h30);
    ext_en <= 8'hcf;
    ext <= 8'h41;
    repeat (8) @(posedge clk_i);
    rdc(PIN_LEVEL_OFF, 8'h71);
    chk({7'h0, timer_counter_clock_in_o}, 8'h01);
    rdc(OUT_LATCH_OFF, 8'h30);
    apb(1'b1, PIN_LEVEL_OFF, 32'h0);
    rdc(OUT_LATCH_OFF, 8'h00);
    $display("t_regs done");
  endtask
  // Oscillator takes pins 0 and 1 over outputs.
  task automatic t_osc();
    cfg(8'h01, 8'h00, 8'hff);
    chk(pin_oe_o, 8'hfc);
    chk({6'h0, osc_analog_en_o}, 8'h03);
    chk({7'h0, timer_counter_clock_in_o}, 8'h00);
    rdc(DIRECTION_OFF, 8'h00);
    $display("t_osc done");
  endtask
  // Compare units, shutdown tri-state, pin select and capture.
  task automatic t_ccp();
    ccp1_out_i <= 1'b1;
    ccp1_out_en_i <= 1'b1;
    ccp2_out_i <= 1'b1;
    ccp2_out_en_i <= 1'b1;
    cfg(8'h0c, 8'h00, 8'h00);
    chk(pin_o & pin_oe_o & 8'h06, 8'h06);
    ccp1_shutdown_tri_i <= 1'b1;
    second_ccp_pin_select_cfg_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk(pin_oe_o & 8'h04, 8'h00);
    chk(pin_o & 8'h02, 8'h00);
    ccp1_out_i <= 1'b0;
    ext_en <= 8'h04;
    ext <= 8'h04;
    apb(1'b1, DIRECTION_OFF, 32'h04);
    repeat (8) @(posedge clk_i);
    chk({7'h0, ccp1_capture_o}, 8'h01);
    // Route the second unit back to pin 1 and capture there as well.
    ext_en <= 8'h06;
    ext <= 8'h06;
    second_ccp_pin_select_cfg_i <= 1'b1;
    apb(1'b1, DIRECTION_OFF, 32'h06);
    repeat (8) @(posedge clk_i);
    chk({6'h0, ccp2_capture_o, ccp1_capture_o}, 8'h03);
    $display("t_ccp done");
  endtask
  // SPI pins, comparator on pin 5, then I2C over SPI clock.
  task automatic t_serial();
    spi_clock_pin_i <= 1'b1;
    spi_data_out_pin_i <= 1'b1;
    ext_en <= 8'h10;
    ext <= 8'h10;
    cfg(8'h10, 8'h10, 8'h00);
    repeat (5) @(posedge clk_i);
    chk(pin_o & pin_oe_o & 8'h28, 8'h28);
    chk({7'h0, spi_data_in_pin_o}, 8'h01);
    comparator_two_output_en_i <= 1'b1;
    apb(1'b1, DIRECTION_OFF, 32'h30);
    chk(pin_oe_o & 8'h20, 8'h20);
    chk(pin_o & 8'h20, 8'h00);
    i2c_clock_pin_oe_i <= 1'b1;
    i2c_schmitt_i <= 1'b1;
    apb(1'b1, DIRECTION_OFF, 32'h10);
    apb(1'b1, PERIPH_CTRL_OFF, 32'h30);
    @(posedge clk_i);
    chk({pin_oe_o[3], pin_o[3], i2c_schmitt_sel_o, 4'h0}, 8'hb0);
    // The low clock line must come back through the pin inputs.
    repeat (8) @(posedge clk_i);
    chk({5'h0, spi_clock_pin_o, i2c_clock_pin_o, i2c_data_pin_o}, 8'h01);
    $display("t_serial done");
  endtask
  // Synchronous USART transmit, then reception on pin 7.
  task automatic t_usart();
    usart_sync_tx_i <= 1'b1;
    usart_sync_clock_pin_i <= 1'b1;
    usart_sync_data_pin_i <= 1'b1;
    cfg(8'hc0, 8'hc0, 8'h00);
    chk(pin_o & pin_oe_o & 8'hc0, 8'hc0);
    usart_sync_tx_i <= 1'b0;
    ext_en <= 8'hc0;
    ext <= 8'hc0;
    apb(1'b1, DIRECTION_OFF, 32'h80);
    repeat (8) @(posedge clk_i);
    chk({6'h0, usart_sync_clock_pin_o, usart_sync_data_pin_o}, 8'h03);
    chk({7'h0, usart_receive_pin_o}, 8'h00);
    // Asynchronous mode: receive comes from pin 7, sync inputs go quiet.
    apb(1'b1, PERIPH_CTRL_OFF, 32'h40);
    repeat (3) @(posedge clk_i);
    chk({7'h0, usart_receive_pin_o}, 8'h01);
    chk({6'h0, usart_sync_clock_pin_o, usart_sync_data_pin_o}, 8'h00);
    $display("t_usart done");
  endtask
  // Unmapped address answers with an error and no data.
  task automatic t_bad();
    apb(1'b0, 12'hff0, 32'h0);
    chk({er, rd[6:0]}, 8'h80);
    $display("t_bad done");
  endtask

  // Main sequence: reset for 8 cycles, then every scenario.
  initial begin
    repeat (8) @(posedge clk_i);
    rst_n_i <= 1'b1;
    t_reset();
    t_regs();
    t_osc();
    t_ccp();
    t_serial();
    t_usart();
    t_bad();
    print_verdict();
  end
endmodule
